// ===== relay_channel.v
// One relay channel: activation and holding delay timer with active level
module relay_channel (
    core_clk,
    rst,
    ms_tick,
    event_true,
    act_delay,
    hold_delay,
    active_level,
    relay_out
);
`include "relay_regs.vh"
    input wire core_clk;
    input wire rst;
    input wire ms_tick;
    input wire event_true;
    input wire [`DLY_W-1:0] act_delay;
    input wire [`DLY_W-1:0] hold_delay;
    input wire active_level;
    output reg relay_out;

    reg state_q;
    reg [`DLY_W-1:0] cnt_q;

    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            state_q <= 1'b0;
            cnt_q <= 16'h0000;
            relay_out <= 1'b0;
        end else begin
            if (event_true == state_q) begin
                cnt_q <= 16'h0000;
            end else if ((event_true ? act_delay : hold_delay) <= cnt_q) begin
                state_q <= event_true;
                cnt_q <= 16'h0000;
            end else if (ms_tick) begin
                cnt_q <= cnt_q + 16'h0001;
            end
            relay_out <= active_level ? state_q : ~state_q;
        end
    end
endmodule

// ===== relay_event_output_delay.v
// Relay event selection, delay configuration and millisecond tick
`include "relay_regs.vh"
module relay_event_output_delay #(
    parameter N_RELAY = 6,
    parameter N_GEN = 32,
    parameter HIGH_POWER = 0,
    parameter TICK_CYCLES = `TICK_CYCLES
) (
    core_clk,
    rst,
    factory_reset,
    cfg_wr,
    cfg_relay,
    cfg_assign,
    cfg_act_delay,
    cfg_hold_delay,
    cfg_active_level,
    mains_contactor_sel_wr,
    mains_contactor_relay,
    output_contactor_sel_wr,
    output_contactor_relay,
    drive_ready,
    drive_running,
    fault_state_event,
    mains_contactor_event,
    dc_charging_event,
    brake_sequence_event,
    output_contactor_event,
    master_slave_warning_event,
    ai3_thermal_event,
    ai3_sensor_event,
    generic_events,
    cfg_refused,
    relay_pins
);
    input wire core_clk;
    input wire rst;
    input wire factory_reset;
    input wire cfg_wr;
    input wire [2:0] cfg_relay;
    input wire [`EV_W-1:0] cfg_assign;
    input wire [`DLY_W-1:0] cfg_act_delay;
    input wire [`DLY_W-1:0] cfg_hold_delay;
    input wire cfg_active_level;
    input wire mains_contactor_sel_wr;
    input wire [2:0] mains_contactor_relay;
    input wire output_contactor_sel_wr;
    input wire [2:0] output_contactor_relay;
    input wire drive_ready;
    input wire drive_running;
    input wire fault_state_event;
    input wire mains_contactor_event;
    input wire dc_charging_event;
    input wire brake_sequence_event;
    input wire output_contactor_event;
    input wire master_slave_warning_event;
    input wire ai3_thermal_event;
    input wire ai3_sensor_event;
    input wire [N_GEN-1:0] generic_events;
    output reg cfg_refused;
    output wire [N_RELAY-1:0] relay_pins;

    // Events are asynchronous to this clock: two stages each
    localparam NEV = 10 + N_GEN;
    wire [NEV-1:0] ev_raw;
    reg [NEV-1:0] ev_s1_q;
    reg [NEV-1:0] ev_s2_q;
    assign ev_raw = {generic_events, ai3_sensor_event, ai3_thermal_event,
                     master_slave_warning_event, output_contactor_event,
                     brake_sequence_event, dc_charging_event, mains_contactor_event,
                     fault_state_event, drive_running, drive_ready};

    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            ev_s1_q <= {NEV{1'b0}};
            ev_s2_q <= {NEV{1'b0}};
        end else begin
            ev_s1_q <= ev_raw;
            ev_s2_q <= ev_s1_q;
        end
    end

    function is_safety;
        input [`EV_W-1:0] a;
        begin
            is_safety = (a == `EV_FAULT_STATE) || (a == `EV_MAINS_CONTACTOR) ||
                        (a == `EV_DC_CHARGING) || (a == `EV_BRAKE_SEQUENCE) ||
                        (a == `EV_OUTPUT_CONTACTOR);
        end
    endfunction

    // Whether an assignment may be chosen on a given relay
    function legal_assign;
        input [`EV_W-1:0] a;
        input [2:0] r;
        begin
            legal_assign = 1'b1;
            if ((r == 3'd0) && ((a == `EV_MASTER_SLAVE_WARN) ||
                (a == `EV_OUTPUT_CONTACTOR) || (a == `EV_MAINS_CONTACTOR) ||
                (a == `EV_DC_CHARGING)))
                legal_assign = 1'b0;
            if (((a == `EV_AI3_THERMAL) || (a == `EV_AI3_SENSOR)) && (HIGH_POWER == 0))
                legal_assign = 1'b0;
            if ((a > `EV_AI3_SENSOR) && (a < `EV_GENERIC_BASE))
                legal_assign = 1'b0;
            if ((a >= `EV_GENERIC_BASE) && ({26'd0, a} - 32'd16 >= N_GEN))
                legal_assign = 1'b0;
            if ((r == 3'd0) || (r != 3'd0))
                legal_assign = legal_assign & ({29'd0, r} < N_RELAY);
        end
    endfunction

    function event_value;
        input [`EV_W-1:0] a;
        input [NEV-1:0] ev;
        begin
            case (a)
                `EV_NONE: event_value = 1'b0;
                `EV_READY_OR_RUN: event_value = ev[0] | ev[1];
                `EV_FAULT_STATE: event_value = ev[2];
                `EV_MAINS_CONTACTOR: event_value = ev[3];
                `EV_DC_CHARGING: event_value = ev[4];
                `EV_BRAKE_SEQUENCE: event_value = ev[5];
                `EV_OUTPUT_CONTACTOR: event_value = ev[6];
                `EV_MASTER_SLAVE_WARN: event_value = ev[7];
                `EV_AI3_THERMAL: event_value = ev[8];
                `EV_AI3_SENSOR: event_value = ev[9];
                default: event_value = (a >= `EV_GENERIC_BASE) ?
                    ev[10 + a - `EV_GENERIC_BASE] : 1'b0;
            endcase
        end
    endfunction

    // Millisecond tick divider
    reg [31:0] div_q;
    reg ms_tick_q;
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            div_q <= 32'h00000000;
            ms_tick_q <= 1'b0;
        end else if (div_q >= TICK_CYCLES - 1) begin
            div_q <= 32'h00000000;
            ms_tick_q <= 1'b1;
        end else begin
            div_q <= div_q + 32'h00000001;
            ms_tick_q <= 1'b0;
        end
    end

    reg [`EV_W-1:0] assign_q [0:N_RELAY-1];
    reg [`DLY_W-1:0] act_q [0:N_RELAY-1];
    reg [`DLY_W-1:0] hold_q [0:N_RELAY-1];
    reg [N_RELAY-1:0] level_q;
    wire wr_ok;
    wire wr_safe;
    assign wr_safe = is_safety(cfg_assign);
    assign wr_ok = legal_assign(cfg_assign, cfg_relay) &&
                   (wr_safe ? ((cfg_act_delay == 16'h0000) && (cfg_hold_delay == 16'h0000))
                            : ((cfg_act_delay <= `ACT_DLY_MAX) &&
                               (cfg_hold_delay <= `HOLD_DLY_MAX)));

    integer i;
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            for (i = 0; i < N_RELAY; i = i + 1) begin
                assign_q[i] <= (i == 0) ? `EV_FAULT_STATE : `EV_NONE;
                act_q[i] <= `ACT_DLY_RESET;
                hold_q[i] <= `HOLD_DLY_RESET;
            end
            level_q <= {N_RELAY{1'b1}};
            cfg_refused <= 1'b0;
        end else if (factory_reset) begin
            for (i = 0; i < N_RELAY; i = i + 1) begin
                assign_q[i] <= (i == 0) ? `EV_FAULT_STATE : `EV_NONE;
                act_q[i] <= `ACT_DLY_RESET;
                hold_q[i] <= `HOLD_DLY_RESET;
            end
            level_q <= {N_RELAY{1'b1}};
            cfg_refused <= 1'b0;
        end else begin
            cfg_refused <= cfg_wr & ~wr_ok;
            if (cfg_wr && wr_ok) begin
                assign_q[cfg_relay] <= cfg_assign;
                act_q[cfg_relay] <= cfg_act_delay;
                hold_q[cfg_relay] <= cfg_hold_delay;
                level_q[cfg_relay] <= wr_safe ? 1'b1 : cfg_active_level;
            end
            if (mains_contactor_sel_wr && (mains_contactor_relay != 3'd0) &&
                ({29'd0, mains_contactor_relay} < N_RELAY)) begin
                assign_q[mains_contactor_relay] <= `EV_MAINS_CONTACTOR;
                act_q[mains_contactor_relay] <= 16'h0000;
                hold_q[mains_contactor_relay] <= 16'h0000;
                level_q[mains_contactor_relay] <= 1'b1;
            end
            if (output_contactor_sel_wr && (output_contactor_relay != 3'd0) &&
                ({29'd0, output_contactor_relay} < N_RELAY)) begin
                assign_q[output_contactor_relay] <= `EV_OUTPUT_CONTACTOR;
                act_q[output_contactor_relay] <= 16'h0000;
                hold_q[output_contactor_relay] <= 16'h0000;
                level_q[output_contactor_relay] <= 1'b1;
            end
        end
    end

    genvar g;
    generate
        for (g = 0; g < N_RELAY; g = g + 1) begin : ch
            relay_channel u_ch (
                .core_clk(core_clk),
                .rst(rst),
                .ms_tick(ms_tick_q),
                .event_true(event_value(assign_q[g], ev_s2_q)),
                .act_delay(act_q[g]),
                .hold_delay(hold_q[g]),
                .active_level(level_q[g]),
                .relay_out(relay_pins[g])
            );
        end
    endgenerate
endmodule

// ===== relay_event_output_delay_checker.sv
// Assertion checker for the relay event output delay block
`include "relay_regs.vh"
module relay_event_output_delay_checker #(
    parameter N_RELAY = 6,
    parameter HIGH_POWER = 0
) (
    input wire core_clk,
    input wire rst,
    input wire cfg_wr,
    input wire [2:0] cfg_relay,
    input wire [`EV_W-1:0] cfg_assign,
    input wire [`DLY_W-1:0] cfg_act_delay,
    input wire [`DLY_W-1:0] cfg_hold_delay,
    input wire fault_state_event,
    input wire cfg_refused,
    input wire [N_RELAY-1:0] relay_pins
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    wire wr0 = cfg_wr && cfg_relay == 3'h0;
    wire wr1 = cfg_wr && cfg_relay != 3'h0 && cfg_relay < N_RELAY;
    wire safe = cfg_assign == `EV_FAULT_STATE || cfg_assign == `EV_MAINS_CONTACTOR
        || cfg_assign == `EV_DC_CHARGING || cfg_assign == `EV_BRAKE_SEQUENCE
        || cfg_assign == `EV_OUTPUT_CONTACTOR;
    wire ai3 = cfg_assign == `EV_AI3_THERMAL || cfg_assign == `EV_AI3_SENSOR;
    wire legal = cfg_assign == `EV_READY_OR_RUN && cfg_act_delay <= `ACT_DLY_MAX
        && cfg_hold_delay <= `HOLD_DLY_MAX;
    sequence s_fault_up; $rose(fault_state_event); endsequence
    sequence s_fault_down; $fell(fault_state_event); endsequence
    sequence s_pin0_on; ##[2:5] relay_pins[0]; endsequence
    sequence s_pin0_off; ##[2:5] !relay_pins[0]; endsequence
    property p_ms_relay0; wr0 && cfg_assign == `EV_MASTER_SLAVE_WARN |=> cfg_refused; endproperty
    property p_oc_relay0; wr0 && cfg_assign == `EV_OUTPUT_CONTACTOR |=> cfg_refused; endproperty
    property p_act_max; cfg_wr && cfg_act_delay > `ACT_DLY_MAX |=> cfg_refused; endproperty
    property p_safe_dly; wr1 && safe && cfg_act_delay != 16'h0000 |=> cfg_refused; endproperty
    property p_ai3; cfg_wr && ai3 && HIGH_POWER == 0 |=> cfg_refused; endproperty
    property p_legal; wr1 && legal |=> !cfg_refused; endproperty
    property p_cause; cfg_refused |-> $past(cfg_wr); endproperty
    property p_fault_on; s_fault_up |-> s_pin0_on; endproperty
    property p_fault_off; s_fault_down |-> s_pin0_off; endproperty
    a_ms_relay0: assert property (p_ms_relay0) else $error("relay 0 master-slave kept");
    a_oc_relay0: assert property (p_oc_relay0) else $error("relay 0 contactor kept");
    a_act_max: assert property (p_act_max) else $error("long delay kept");
    a_safe_dly: assert property (p_safe_dly) else $error("safety delay kept");
    a_ai3: assert property (p_ai3) else $error("ai3 warning kept");
    a_legal: assert property (p_legal) else $error("legal write refused");
    a_cause: assert property (p_cause) else $error("refusal without write");
    a_fault_on: assert property (p_fault_on) else $error("relay 0 late on");
    a_fault_off: assert property (p_fault_off) else $error("relay 0 late off");
endmodule
bind relay_event_output_delay relay_event_output_delay_checker #(
    .N_RELAY(N_RELAY), .HIGH_POWER(HIGH_POWER)
) chk (
    .core_clk(core_clk), .rst(rst), .cfg_wr(cfg_wr), .cfg_relay(cfg_relay),
    .cfg_assign(cfg_assign), .cfg_act_delay(cfg_act_delay), .cfg_hold_delay(cfg_hold_delay),
    .fault_state_event(fault_state_event), .cfg_refused(cfg_refused), .relay_pins(relay_pins)
);

// ===== relay_load_model.sv
// Contactor load model closing a few cycles after its coil is driven
module relay_load_model #(parameter N = 6, parameter PICKUP = 3) (
    input wire core_clk,
    input wire [N-1:0] coil,
    output logic [N-1:0] closed
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [N-1:0] stage [PICKUP];
    always @(posedge core_clk) begin
        stage[0] <= coil;
        for (int i = 1; i < PICKUP; i++) stage[i] <= stage[i-1];
    end
    assign closed = stage[PICKUP-1];
endmodule

// ===== relay_regs.vh
// Constants for the relay event output delay block
// Function
// - Relay changes state only after its activation delay once its event becomes true.
// - Activation delay programmable 0 to 60000 ms in 1 ms steps.
// - Factory configuration restores every activation delay to zero.
// - Safety-related assignments force delay to zero and refuse delay writes.
// - First relay defaults to operating-state-fault event; others unassigned.
// - Contactor assign selects relay and sets its assignment to that contactor event.
// - Ready-or-running event is true when drive is ready or running.
// - Third analog input thermal/sensor warnings offered only above 22 kW variants.
// - Master-slave warning and output-contactor not selectable on first relay.
// - Active level positive drives 1 on true event, negative drives 0.
// - Event going false waits a separate holding delay before release.
`ifndef RELAY_REGS_VH
`define RELAY_REGS_VH
`define EV_W 6
`define EV_NONE 6'h00
`define EV_FAULT_STATE 6'h01
`define EV_MAINS_CONTACTOR 6'h02
`define EV_DC_CHARGING 6'h03
`define EV_BRAKE_SEQUENCE 6'h04
`define EV_OUTPUT_CONTACTOR 6'h05
`define EV_MASTER_SLAVE_WARN 6'h06
`define EV_READY_OR_RUN 6'h07
`define EV_AI3_THERMAL 6'h08
`define EV_AI3_SENSOR 6'h09
`define EV_GENERIC_BASE 6'h10
`define DLY_W 16
`define ACT_DLY_MAX 16'hEA60
`define HOLD_DLY_MAX 16'h270F
`define ACT_DLY_RESET 16'h0000
`define HOLD_DLY_RESET 16'h0000
`define TICK_PERIOD_NS 1000000
`define CLK_PERIOD_NS 10
`define TICK_CYCLES (`TICK_PERIOD_NS / `CLK_PERIOD_NS)
`endif

// ===== tb_relay_event_output_delay.sv
// Self-checking bench for the relay event output delay block
`include "relay_regs.vh"
module tb_relay_event_output_delay;
    timeunit 1ns;
    timeprecision 1ns;
    logic core_clk = 0, rst = 1, factory_reset = 0, cfg_wr = 0, cfg_level = 1, got;
    logic [2:0] cfg_relay = 0, mc_relay = 0, oc_relay = 0;
    logic [5:0] cfg_assign = 0, relay_pins, closed;
    logic [15:0] cfg_act = 0, cfg_hold = 0;
    logic mc_wr = 0, oc_wr = 0, rdy = 0, run = 0, fault = 0, mains = 0, brake = 0, outc = 0;
    logic dcc = 0;
    logic [31:0] gen_ev = 0;
    logic cfg_refused;
    int n_errors = 0, checked = 0;
    relay_event_output_delay #(.TICK_CYCLES(10)) dut (
        .core_clk(core_clk), .rst(rst), .factory_reset(factory_reset), .cfg_wr(cfg_wr),
        .cfg_relay(cfg_relay), .cfg_assign(cfg_assign), .cfg_act_delay(cfg_act),
        .cfg_hold_delay(cfg_hold), .cfg_active_level(cfg_level),
        .mains_contactor_sel_wr(mc_wr), .mains_contactor_relay(mc_relay),
        .output_contactor_sel_wr(oc_wr), .output_contactor_relay(oc_relay),
        .drive_ready(rdy), .drive_running(run), .fault_state_event(fault),
        .mains_contactor_event(mains), .dc_charging_event(dcc),
        .brake_sequence_event(brake), .output_contactor_event(outc),
        .master_slave_warning_event(1'b0), .ai3_thermal_event(1'b0),
        .ai3_sensor_event(1'b0), .generic_events(gen_ev), .cfg_refused(cfg_refused),
        .relay_pins(relay_pins)
    );
    relay_load_model load (.core_clk(core_clk), .coil(relay_pins), .closed(closed));
    initial forever #5 core_clk = ~core_clk;
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(negedge core_clk);
    endtask
    task automatic wr(input logic [2:0] r, input logic [5:0] a, input logic [15:0] ad, hd,
                      input logic lv);
        @(negedge core_clk);
        {cfg_relay, cfg_assign, cfg_act, cfg_hold, cfg_level, cfg_wr} = {r, a, ad, hd, lv, 1'b1};
        @(negedge core_clk);
        got = cfg_refused;
        cfg_wr = 0;
    endtask
    task automatic pulse_factory;
        factory_reset = 1;
        tick(1);
        factory_reset = 0;
        tick(6);
    endtask
    task automatic t_defaults;
        pulse_factory();
        check(relay_pins, 6'h00);
        fault = 1;
        tick(6);
        check(relay_pins, 6'h01);
        fault = 0;
        tick(6);
        check(relay_pins, 6'h00);
    endtask
    task automatic t_act_delay;
        wr(3'h1, `EV_READY_OR_RUN, 16'h0003, 16'h0000, 1'b1);
        check(got, 1'b0);
        rdy = 1;
        tick(15);
        rdy = 0;
        tick(40);
        check(relay_pins[1], 1'b0);
        rdy = 1;
        tick(15);
        check(relay_pins[1], 1'b0);
        tick(35);
        check(relay_pins[1], 1'b1);
        rdy = 0;
        tick(6);
        check(relay_pins[1], 1'b0);
    endtask
    task automatic t_hold;
        wr(3'h2, `EV_READY_OR_RUN, 16'h0000, 16'h0004, 1'b0);
        tick(6);
        check(relay_pins[2], 1'b1);
        run = 1;
        tick(6);
        check(relay_pins[2], 1'b0);
        run = 0;
        tick(20);
        check(relay_pins[2], 1'b0);
        tick(40);
        check(relay_pins[2], 1'b1);
    endtask
    task automatic t_refusals;
        logic [40:0] tbl [12] = '{{3'h0, `EV_MASTER_SLAVE_WARN, 32'h0},
            {3'h0, `EV_OUTPUT_CONTACTOR, 32'h0}, {3'h1, `EV_FAULT_STATE, 32'h50000},
            {3'h1, `EV_MAINS_CONTACTOR, 32'h10000}, {3'h1, `EV_DC_CHARGING, 32'h1},
            {3'h1, `EV_BRAKE_SEQUENCE, 32'h10000}, {3'h1, `EV_OUTPUT_CONTACTOR, 32'h10000},
            {3'h1, `EV_AI3_THERMAL, 32'h0}, {3'h1, `EV_AI3_SENSOR, 32'h0},
            {3'h1, `EV_READY_OR_RUN, 32'hEA610000}, {3'h1, `EV_READY_OR_RUN, 32'h2710},
            {3'h6, `EV_READY_OR_RUN, 32'h0}};
        for (int i = 0; i < 12; i++) begin
            wr(tbl[i][40:38], tbl[i][37:32], tbl[i][31:16], tbl[i][15:0], 1'b1);
            check(got, 1'b1);
        end
        wr(3'h3, `EV_READY_OR_RUN, 16'hEA60, 16'h270F, 1'b1);
        check(got, 1'b0);
        wr(3'h3, `EV_BRAKE_SEQUENCE, 16'h0000, 16'h0000, 1'b1);
        check(got, 1'b0);
        brake = 1;
        tick(6);
        check(relay_pins[3], 1'b1);
    endtask
    task automatic t_aux_events;
        wr(3'h1, `EV_DC_CHARGING, 16'h0000, 16'h0000, 1'b0);
        check(got, 1'b0);
        dcc = 1;
        tick(6);
        check(relay_pins[1], 1'b1);
        dcc = 0;
        tick(6);
        check(relay_pins[1], 1'b0);
        wr(3'h1, 6'h30, 16'h0000, 16'h0000, 1'b1);
        check(got, 1'b1);
        wr(3'h1, 6'h0A, 16'h0000, 16'h0000, 1'b1);
        check(got, 1'b1);
        wr(3'h1, 6'h2F, 16'h0000, 16'h0000, 1'b0);
        check(got, 1'b0);
        tick(6);
        check(relay_pins[1], 1'b1);
        gen_ev = 32'h80000000;
        tick(6);
        check(relay_pins[1], 1'b0);
    endtask
    task automatic t_contactor;
        {mc_wr, mc_relay, oc_wr, oc_relay} = {1'b1, 3'h4, 1'b1, 3'h5};
        tick(1);
        {mc_wr, oc_wr, mains, outc} = 4'h3;
        tick(6);
        check(relay_pins[5:4], 2'h3);
        tick(4);
        check(closed[5:4], 2'h3);
        {mc_wr, mc_relay} = {1'b1, 3'h0};
        tick(1);
        mc_wr = 0;
        tick(6);
        check(relay_pins[0], 1'b0);
        pulse_factory();
        check(relay_pins, 6'h00);
    endtask
    task automatic tally_and_finish;
        $display("Comparisons %0d, mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge core_clk);
        n_errors++;
        tally_and_finish();
    end
    initial begin
        tick(4);
        rst = 0;
        t_defaults();
        t_act_delay();
        t_hold();
        t_refusals();
        t_aux_events();
        t_contactor();
        tally_and_finish();
    end
endmodule
